// *** rtl/mmc_measure_config.sv ***
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Trigger events accepted only with trigger enable 1 and pin select 0.
// - With triggering enabled, pin high starts an acquisition.
// - Acquisitions keep restarting while pin stays high; host drives low to stop.
// - Compensation enable 1 applies drift compensation, 0 bypasses it.
// - Compensation enable selects the encoding of magnetic results.
// - Comp off: res 0/1 two's complement; res 2/3 offset 2^15/2^14, clamped.
// - Comp on: res 0/1 unsigned around 2^15; res 2/3 not supported.
// - Burst command with zero axis argument converts the burst axis field.
// - Two-bit temperature oversampling field sets temperature converter ratio.
// - Two-bit magnetic oversampling field sets magnetic ratio.
// - Six-bit resolution field, two bits per axis X, Y, Z.
// - Two-bit digital filter field steers magnetic conversion time.
// - Hot factor above reference temperature, cold factor below.
// - Sixteen-bit constant offset correction per axis X, Y, Z.
// - Sixteen-bit change threshold per axis and temperature.
// - Pin select 0 makes the shared pin trigger input, 1 interrupt output.
// - Reference mode picks previous measurement or first measurement as reference.
module mmc_measure_config #(
  parameter logic [15:0] TEMP_REF = 16'h8000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_interrupt_pin_in,
  output logic trigger_interrupt_pin_out,
  output logic trigger_interrupt_pin_oe,
  output logic irq,
  output logic conv_start,
  output mmc_pkg::mmc_conv_t conv_req,
  output logic drift_compensation_on,
  input wire logic raw_valid,
  input wire mmc_pkg::mmc_raw_t raw
);
  import mmc_pkg::*;

  // One state struct, one next-state process, one register process:
  // every flop of the block lives in state_r.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mmc_cfg_t cfg;
    logic [7:0] drift_factor_hot;
    logic [7:0] drift_factor_cold;
    logic [2:0][15:0] offs;
    logic [NUM_CH-1:0][15:0] change_threshold;
    logic [NUM_CH-1:0][15:0] res;
    logic [NUM_CH-1:0][16:0] refv;
    logic ref_ok;
    logic burst;
    logic [3:0] burst_axes;
    logic [3:0] axes;
    logic [NUM_EV-1:0] stat;
    logic [NUM_EV-1:0] ien;
    mmc_st_t st;
    logic [31:0] prdata;
    logic conv_start;
    logic irq;
  } mmc_state_t;

  mmc_state_t state_r;
  mmc_state_t state_nxt;

  logic setup_ph;
  logic wr_acc;
  logic mapped;
  logic trig_ok;
  logic [31:0] rdata;
  logic [NUM_EV-1:0] ev_clr;
  logic [NUM_CH-1:0][15:0] fmt;
  logic [NUM_CH-1:0][16:0] cmpv;
  logic [NUM_CH-1:0] hit;

  // Axis sums carry guard bits above the 16-bit code,
  // so offset plus field clamps instead of wrapping.
  // Temperature stays an unsigned code throughout.

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Read data is captured in setup, so access always completes at once
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign ev_clr = (wr_acc && paddr == ADDR_ICLR) ? pwdata[NUM_EV-1:0] : '0;

  // Writes to read-only words drop quietly;
  // only an unmapped address raises the error flag.
  // No wait states: software never stalls here.

  // Trigger only counts while the pin is configured as input
  assign trig_ok = state_r.cfg.external_trigger_enable &
                   ~state_r.cfg.trigger_interrupt_pin_select &
                   trigger_interrupt_pin_in;
  // Level sense, no edge detector:
  // no false start after reset while the pin idles.

  // Read mux and address map
  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    case (paddr)
      ADDR_CFG: rdata = {{(32 - $bits(mmc_cfg_t)){1'b0}}, state_r.cfg};
      ADDR_DRIFT: rdata = {16'h0000, state_r.drift_factor_hot, state_r.drift_factor_cold};
      ADDR_OFFX: rdata = {16'h0000, state_r.offs[0]};
      ADDR_OFFY: rdata = {16'h0000, state_r.offs[1]};
      ADDR_OFFZ: rdata = {16'h0000, state_r.offs[2]};
      ADDR_THRT: rdata = {16'h0000, state_r.change_threshold[0]};
      ADDR_THRX: rdata = {16'h0000, state_r.change_threshold[1]};
      ADDR_THRY: rdata = {16'h0000, state_r.change_threshold[2]};
      ADDR_THRZ: rdata = {16'h0000, state_r.change_threshold[3]};
      ADDR_CMD: rdata = '0;
      ADDR_STAT: rdata = {{(32 - NUM_EV){1'b0}}, state_r.stat};
      ADDR_ICLR: rdata = '0;
      ADDR_IEN: rdata = {{(32 - NUM_EV){1'b0}}, state_r.ien};
      ADDR_REST: rdata = {16'h0000, state_r.res[0]};
      ADDR_RESX: rdata = {16'h0000, state_r.res[1]};
      ADDR_RESY: rdata = {16'h0000, state_r.res[2]};
      ADDR_RESZ: rdata = {16'h0000, state_r.res[3]};
      ADDR_ACQ: rdata = {24'h000000, state_r.burst_axes, 2'b00,
                         state_r.burst, (state_r.st == MMC_CONV)};
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Per-channel correction, encoding and change compare
  // ----------------------------------------------------------------
  // Both factors are signed; at the exact
  // reference code the cold factor is used.
  // Temperature code sits above the reference: hot factor applies
  logic hot_side;
  logic signed [8:0] factor;
  assign hot_side = raw.ch[0] > TEMP_REF;
  assign factor = hot_side ? {state_r.drift_factor_hot[7], state_r.drift_factor_hot}
                           : {state_r.drift_factor_cold[7], state_r.drift_factor_cold};

  // Temperature is passed on as raw unsigned code
  assign fmt[0] = raw.ch[0];
  assign cmpv[0] = {1'b0, raw.ch[0]};
  assign hit[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 1; gi < NUM_CH; gi++) begin : g_axis
      logic [1:0] rsel;
      logic signed [17:0] sum;
      logic signed [26:0] prod;
      logic signed [17:0] comp;
      logic signed [17:0] lim;
      logic signed [17:0] clp;
      logic [15:0] base;
      logic [15:0] mid;
      logic signed [18:0] dif;
      logic [18:0] mag;

      assign rsel = state_r.cfg.axis_resolution_field[(3 - gi) * 2 +: 2];
      // Offset is added before compensation, independent of temperature
      assign sum = 18'($signed(raw.ch[gi])) + 18'($signed(state_r.offs[gi - 1]));
      assign prod = 27'(sum * factor);
      assign comp = state_r.cfg.drift_compensation_enable ?
                    18'(sum + 18'(prod >>> DRIFT_SHIFT)) : sum;

      // Limits and code offsets depend on config only
      // Reduced ranges for the two finest resolutions without compensation
      always_comb begin
        lim = LIM_FULL;
        mid = 16'h0000;
        if (state_r.cfg.drift_compensation_enable) begin
          mid = MID_15;
        end else begin
          case (rsel)
            2'd2: begin
              lim = LIM_RES2;
              mid = MID_15;
            end
            2'd3: begin
              lim = LIM_RES3;
              mid = MID_14;
            end
            default: mid = 16'h0000;
          endcase
        end
      end

      // Full range has one more code below zero; reduced ones are symmetric
      logic signed [17:0] lim_lo;
      assign lim_lo = (lim == LIM_FULL) ? (-lim - 18'sd1) : -lim;

      // Comp with res 2/3 is unsupported; it falls back to the 2^15 code
      assign clp = (comp > lim) ? lim :
                   (comp < lim_lo) ? lim_lo : comp;
      assign base = clp[15:0];
      assign fmt[gi] = base + mid;
      assign cmpv[gi] = clp[16:0];

      // Code offsets differ per resolution, so encoded
      // codes would give false events after a change.
      // Compare on the signed corrected value, not the encoded one
      assign dif = 19'($signed(cmpv[gi])) - 19'($signed(state_r.refv[gi]));
      assign mag = dif[18] ? 19'(-dif) : 19'(dif);
      assign hit[gi] = state_r.axes[gi] &
                       (mag > {3'b000, state_r.change_threshold[gi]});
    end
  endgenerate

  // No offset or drift factor for temperature,
  // so its compare works on the raw code.
  // Temperature channel compare uses unsigned codes
  logic [17:0] tdif;
  logic [17:0] tmag;
  logic thit;
  assign tdif = {1'b0, cmpv[0]} - {1'b0, state_r.refv[0]};
  assign tmag = tdif[17] ? 18'(-tdif) : tdif;
  assign thit = state_r.axes[0] &
                (tmag > {2'b00, state_r.change_threshold[0]});

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_EV-1:0] ev_set;
    logic [3:0] arg;
    ev_set = '0;
    arg = pwdata[3:0];
    state_nxt = state_r;
    state_nxt.conv_start = 1'b0;
    if (setup_ph) begin
      state_nxt.prdata = rdata;
    end

    // Read data is latched in setup, so a read never
    // sees a write landing in its own access cycle.
    // Register writes take effect at the access edge only
    if (wr_acc) begin
      case (paddr)
        ADDR_CFG: state_nxt.cfg = pwdata[$bits(mmc_cfg_t)-1:0];
        ADDR_DRIFT: begin
          state_nxt.drift_factor_hot = pwdata[15:8];
          state_nxt.drift_factor_cold = pwdata[7:0];
        end
        ADDR_OFFX: state_nxt.offs[0] = pwdata[15:0];
        ADDR_OFFY: state_nxt.offs[1] = pwdata[15:0];
        ADDR_OFFZ: state_nxt.offs[2] = pwdata[15:0];
        ADDR_THRT: state_nxt.change_threshold[0] = pwdata[15:0];
        ADDR_THRX: state_nxt.change_threshold[1] = pwdata[15:0];
        ADDR_THRY: state_nxt.change_threshold[2] = pwdata[15:0];
        ADDR_THRZ: state_nxt.change_threshold[3] = pwdata[15:0];
        ADDR_CMD: begin
          if (pwdata[CMD_STOP_BIT]) begin
            state_nxt.burst = 1'b0;
          end else if (pwdata[CMD_START_BIT]) begin
            state_nxt.burst = 1'b1;
            state_nxt.burst_axes = (arg == 4'h0) ? state_r.cfg.burst_axis_select : arg;
          end
        end
        ADDR_IEN: state_nxt.ien = pwdata[NUM_EV-1:0];
        default: state_nxt.ien = state_nxt.ien;
      endcase
    end

    // Without change wake the reference is forgotten,
    // so re-enabling starts from a fresh first result.
    if (!state_r.cfg.change_wake_enable) begin
      state_nxt.ref_ok = 1'b0;
    end

    // Stop beats start in one command word, so
    // software can always park the sequencer.

    // Acquisition sequencer
    case (state_r.st)
      MMC_IDLE: begin
        // Level sense: a held-high pin restarts after every result
        if (state_r.burst || trig_ok) begin
          state_nxt.st = MMC_CONV;
          state_nxt.conv_start = 1'b1;
          state_nxt.axes = state_r.burst ? state_r.burst_axes
                                         : state_r.cfg.burst_axis_select;
        end
      end
      MMC_CONV: begin
        if (raw_valid) begin
          state_nxt.st = MMC_IDLE;
          ev_set[EV_DRDY] = 1'b1;
          for (int i = 0; i < NUM_CH; i++) begin
            if (state_r.axes[i]) begin
              state_nxt.res[i] = fmt[i];
            end
          end
          if (state_r.cfg.change_wake_enable) begin
            if (!state_r.ref_ok) begin
              state_nxt.refv = cmpv;
              state_nxt.ref_ok = 1'b1;
            end else begin
              ev_set[EV_WOC] = (|hit) | thit;
              if (state_r.cfg.change_reference_mode) begin
                state_nxt.refv = cmpv;
              end
            end
          end
        end
      end
      default: state_nxt.st = MMC_IDLE;
    endcase

    // A set in the clearing cycle survives, so a
    // result landing during a clear is never lost.
    state_nxt.stat = (state_r.stat & ~ev_clr) | ev_set;
    state_nxt.irq = |(state_nxt.stat & state_nxt.ien);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Thresholds come up at all ones: no change event
  // before software sets them. Reset loads constants only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
      state_r.cfg <= RST_CFG;
      state_r.drift_factor_hot <= RST_FACTOR;
      state_r.drift_factor_cold <= RST_FACTOR;
      state_r.offs <= {3{RST_OFFSET}};
      state_r.change_threshold <= {NUM_CH{RST_THRESH}};
      state_r.st <= MMC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data outputs come from flops or config bits,
  // so none of them glitch with the bus inputs.
  assign prdata = state_r.prdata;
  assign irq = state_r.irq;
  assign conv_start = state_r.conv_start;
  assign drift_compensation_on = state_r.cfg.drift_compensation_enable;
  // Shared pin drives only in interrupt role
  assign trigger_interrupt_pin_oe = state_r.cfg.trigger_interrupt_pin_select;
  assign trigger_interrupt_pin_out = state_r.cfg.trigger_interrupt_pin_select & state_r.irq;

  // Settings follow the config word at once; the front
  // end decides how a mid-conversion change applies.
  assign conv_req.axes = state_r.axes;
  assign conv_req.magnetic_oversampling = state_r.cfg.magnetic_oversampling;
  assign conv_req.temperature_oversampling = state_r.cfg.temperature_oversampling;
  assign conv_req.digital_filter_select = state_r.cfg.digital_filter_select;
  assign conv_req.axis_resolution_field = state_r.cfg.axis_resolution_field;

endmodule : mmc_measure_config

`default_nettype wire

// *** rtl/mmc_pkg.sv ***
package mmc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_DRIFT = 8'h04;
  localparam logic [7:0] ADDR_OFFX = 8'h08;
  localparam logic [7:0] ADDR_OFFY = 8'h0c;
  localparam logic [7:0] ADDR_OFFZ = 8'h10;
  localparam logic [7:0] ADDR_THRT = 8'h14;
  localparam logic [7:0] ADDR_THRX = 8'h18;
  localparam logic [7:0] ADDR_THRY = 8'h1c;
  localparam logic [7:0] ADDR_THRZ = 8'h20;
  localparam logic [7:0] ADDR_CMD = 8'h24;
  localparam logic [7:0] ADDR_STAT = 8'h28;
  localparam logic [7:0] ADDR_ICLR = 8'h2c;
  localparam logic [7:0] ADDR_IEN = 8'h30;
  localparam logic [7:0] ADDR_REST = 8'h34;
  localparam logic [7:0] ADDR_RESX = 8'h38;
  localparam logic [7:0] ADDR_RESY = 8'h3c;
  localparam logic [7:0] ADDR_RESZ = 8'h40;
  localparam logic [7:0] ADDR_ACQ = 8'h44;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CMD_START_BIT = 4;
  localparam int CMD_STOP_BIT = 5;
  localparam int EV_DRDY = 0;
  localparam int EV_WOC = 1;
  localparam int NUM_EV = 2;
  localparam int NUM_CH = 4;
  localparam logic [7:0] RST_FACTOR = 8'h00;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_THRESH = 16'hffff;

  // Drift factor is a signed fraction of 2^DRIFT_SHIFT
  localparam int DRIFT_SHIFT = 12;
  localparam logic signed [17:0] LIM_FULL = 18'sh07fff;
  localparam logic signed [17:0] LIM_RES2 = 18'sd22000;
  localparam logic signed [17:0] LIM_RES3 = 18'sd11000;
  localparam logic [15:0] MID_15 = 16'h8000;
  localparam logic [15:0] MID_14 = 16'h4000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic external_trigger_enable;
    logic trigger_interrupt_pin_select;
    logic drift_compensation_enable;
    logic change_reference_mode;
    logic change_wake_enable;
    logic [3:0] burst_axis_select;
    logic [5:0] axis_resolution_field;
    logic [1:0] digital_filter_select;
    logic [1:0] magnetic_oversampling;
    logic [1:0] temperature_oversampling;
  } mmc_cfg_t;

  localparam mmc_cfg_t RST_CFG = '0;

  typedef struct packed {
    logic [3:0] axes;
    logic [1:0] magnetic_oversampling;
    logic [1:0] temperature_oversampling;
    logic [1:0] digital_filter_select;
    logic [5:0] axis_resolution_field;
  } mmc_conv_t;

  typedef struct packed {
    logic [NUM_CH-1:0][15:0] ch;
  } mmc_raw_t;

  typedef enum logic [0:0] {
    MMC_IDLE,
    MMC_CONV
  } mmc_st_t;

endpackage : mmc_pkg

// *** dv/mmc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port-level checker
// ----------------------------------------------------------------
module mmc_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic trigger_interrupt_pin_out,
  input wire logic trigger_interrupt_pin_oe,
  input wire logic irq,
  input wire logic conv_start,
  input wire mmc_pkg::mmc_conv_t conv_req,
  input wire logic drift_compensation_on,
  input wire logic raw_valid
);
  import mmc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic any_wr;
  logic cfg_wr;
  // Settings may only move after a completed write to the config word
  assign any_wr = psel && penable && pwrite;
  assign cfg_wr = any_wr && paddr == ADDR_CFG;

  comp_follow_a: assert property ($changed(drift_compensation_on) |-> $past(cfg_wr))
    else $error("compensation switch moved without config write");
  pin_dir_a: assert property ($changed(trigger_interrupt_pin_oe) |-> $past(cfg_wr))
    else $error("pin direction moved without config write");
  pin_out_a: assert property (trigger_interrupt_pin_out == (trigger_interrupt_pin_oe && irq))
    else $error("shared pin does not mirror interrupt in output mode");
  tosr_hold_a: assert property ($changed(conv_req.temperature_oversampling) |-> $past(cfg_wr))
    else $error("temperature oversampling moved on its own");
  mosr_hold_a: assert property ($changed(conv_req.magnetic_oversampling) |-> $past(cfg_wr))
    else $error("magnetic oversampling moved on its own");
  res_hold_a: assert property ($changed(conv_req.axis_resolution_field) |-> $past(cfg_wr))
    else $error("resolution field moved on its own");
  filt_hold_a: assert property ($changed(conv_req.digital_filter_select) |-> $past(cfg_wr))
    else $error("filter select moved on its own");
  // A start is one cycle wide and at least two idle cycles follow it
  start_gap_a: assert property (conv_start |=> !conv_start [*2])
    else $error("conversion start too long or too soon again");
  irq_cause_a: assert property ($rose(irq) |-> $past(raw_valid) || $past(raw_valid, 2)
    || $past(any_wr) || $past(any_wr, 2)) else $error("interrupt rose without a cause");
  unmapped_a: assert property (psel && penable && paddr > ADDR_ACQ |-> pslverr)
    else $error("unmapped access not flagged");

  cov_start_c: cover property (conv_start);
  cov_irq_c: cover property ($rose(irq));
  cov_pin_c: cover property (trigger_interrupt_pin_out);
endmodule : mmc_monitor

bind mmc_measure_config mmc_monitor u_mon (.ref_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pslverr, .trigger_interrupt_pin_out, .trigger_interrupt_pin_oe, .irq,
  .conv_start, .conv_req, .drift_compensation_on, .raw_valid);
`default_nettype wire

// *** dv/mmc_front_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Front end stand-in: answers each start after a delay
// ----------------------------------------------------------------
module mmc_front_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic slow,
  input wire mmc_pkg::mmc_raw_t raw_in,
  output logic raw_valid,
  output mmc_pkg::mmc_raw_t raw
);
  import mmc_pkg::*;
  int cnt;
  // Raw bus toggles outside the valid cycle, so stale data never looks good
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      raw_valid <= 1'b0;
      raw <= '0;
    end else begin
      raw_valid <= cnt == 1;
      raw <= (cnt == 1) ? raw_in : ~raw;
      if (conv_start) cnt <= slow ? 20 : 6;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : mmc_front_model
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module testbench;
  import mmc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_out, pin_oe, irq, conv_start, comp_on, raw_valid;
  logic pin_in = 1'b0;
  logic slow = 1'b0;
  mmc_conv_t conv_req;
  mmc_raw_t raw;
  mmc_raw_t raw_set = '0;
  logic [3:0] last_axes;
  logic [32:0] exp_q[$];
  int n_errors = 0;
  int checks = 0;
  int n_starts = 0;
  int n_done = 0;

  initial forever #5 ref_clk = ~ref_clk;

  mmc_measure_config DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .trigger_interrupt_pin_in(pin_in),
    .trigger_interrupt_pin_out(pin_out), .trigger_interrupt_pin_oe(pin_oe), .irq,
    .conv_start, .conv_req, .drift_compensation_on(comp_on), .raw_valid, .raw);
  mmc_front_model u_fe (.ref_clk, .rst_n, .conv_start, .slow, .raw_in(raw_set),
    .raw_valid, .raw);

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic hang;
    n_errors++;
    $display("CHECK FAILED %0t: wait ran out", $time);
    tally_and_finish();
  endtask : hang

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k == 40) hang();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_cnt(ref int c, input int base);
    int k;
    k = 0;
    while (c <= base && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 200) hang();
  endtask : wait_cnt

  // One burst conversion, stopped before the result lands
  task automatic conv_once(input logic [3:0] axes, input logic [3:0] arg = 4'h0);
    int s;
    int d;
    s = n_starts;
    d = n_done;
    wr(ADDR_CMD, {27'h0, 1'b1, arg});
    wait_cnt(n_starts, s);
    wr(ADDR_CMD, 32'h20);
    chk(last_axes, axes);
    wait_cnt(n_done, d);
    repeat (2) @(posedge ref_clk);
  endtask : conv_once

  // Expected result code: correction, clamp, then offset encoding
  function automatic logic [15:0] enc(input int s, input int res, input logic comp,
                                      input int f);
    int lim;
    int lo;
    if (comp) s = s + ((s * f) >>> 12);
    lim = res == 2 ? 22000 : (res == 3 ? 11000 : 32767);
    lo = res < 2 ? -32768 : -lim;
    if (s > lim) s = lim;
    if (s < lo) s = lo;
    return 16'(s + (comp || res == 2 ? 32768 : (res == 3 ? 16384 : 0)));
  endfunction : enc

  // Result watcher: oldest note against each completed read
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) begin
      n_starts++;
      last_axes = conv_req.axes;
    end
    if (raw_valid === 1'b1) n_done++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end

  initial begin
    logic [31:0] v;
    logic [5:0] rf;
    int s;
    int x;
    int off[3];
    int rw[3];
    void'($urandom(32'h9f9284ba));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_CFG, 32'h0);
    rd(ADDR_DRIFT, 32'h0);
    for (int i = 0; i < 3; i++) rd(ADDR_OFFX + 8'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++) rd(ADDR_THRT + 8'(4 * i), 32'hffff);
    rd(8'h48, 32'h0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      wr(ADDR_DRIFT + 8'(4 * i), v);
      rd(ADDR_DRIFT + 8'(4 * i), v & 32'hffff);
    end
    repeat (3) begin
      v = $urandom() & 32'h1fffff;
      wr(ADDR_CFG, v);
      rd(ADDR_CFG, v);
      chk(conv_req.temperature_oversampling, v[1:0]);
      chk(conv_req.magnetic_oversampling, v[3:2]);
      chk(conv_req.digital_filter_select, v[5:4]);
      chk(conv_req.axis_resolution_field, v[11:6]);
      chk({pin_oe, comp_on}, v[19:18]);
    end
    // Pin starts repeat only with trigger enabled in trigger mode
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CFG, 32'h0f000 | (i < 2 ? 32'h100000 : 32'h0) | (i == 1 ? 32'h80000 : 32'h0));
      s = n_starts;
      pin_in <= 1'b1;
      repeat (60) @(posedge ref_clk);
      pin_in <= 1'b0;
      repeat (30) @(posedge ref_clk);
      x = n_starts - s;
      chk(33'(x > 1 ? 2 : x), 33'(i == 0 ? 2 : 0));
      s = n_starts;
      repeat (40) @(posedge ref_clk);
      chk(33'(n_starts - s), 33'h0);
    end
    // Output coding over every resolution, then compensation hot and cold
    wr(ADDR_DRIFT, 32'h40c0);
    for (int c = 0; c < 6; c++) begin
      rf = c < 4 ? 6'(c * 21) : (c == 4 ? 6'h04 : 6'h00);
      slow <= c[0];
      raw_set.ch[0] <= c == 5 ? 16'h1000 : 16'h9000;
      for (int i = 0; i < 3; i++) begin
        off[i] = $urandom_range(200) - 100;
        rw[i] = i == 0 ? 30000 : $urandom_range(60000) - 30000;
        wr(ADDR_OFFX + 8'(4 * i), {16'h0, 16'(off[i])});
        raw_set.ch[i + 1] <= 16'(rw[i]);
      end
      wr(ADDR_CFG, {13'h0, c > 3, 2'b0, 4'hf, rf, 6'h0});
      conv_once(4'hf);
      for (int i = 0; i < 3; i++)
        rd(ADDR_RESX + 8'(4 * i), {16'h0, enc(rw[i] + off[i], int'((rf >> (4 - 2 * i)) & 3),
          c > 3, c == 5 ? -64 : 64)});
    end
    // Interrupt raised, cleared and masked, shown on the shared pin
    wr(ADDR_CFG, 32'h8f000);
    wr(ADDR_IEN, 32'h1);
    conv_once(4'hf);
    chk({pin_out, irq}, 2'b11);
    rd(ADDR_STAT, 32'h1);
    wr(ADDR_ICLR, 32'h1);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(ADDR_IEN, 32'h0);
    conv_once(4'h9, 4'h9);
    chk({pin_oe, pin_out, irq}, 3'b100);
    rd(ADDR_STAT, 32'h1);
    // Change event against the first result or against the previous one
    wr(ADDR_THRX, 32'd10);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CFG, 32'h2000);
      wr(ADDR_CFG, 32'h12000 | (32'(m) << 17));
      wr(ADDR_ICLR, 32'h3);
      for (int j = 0; j < 3; j++) begin
        raw_set.ch[1] <= 16'(100 + 3 * j + 2 * j * j);
        conv_once(4'h2);
      end
      rd(ADDR_STAT, {30'h0, m == 0, 1'b1});
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
